/* File: logic/sac_pkg.sv */
// constants and types of the stack arithmetic command unit
// assumes a 32-bit word stack of four entries and one core clock
package sac_pkg;

	localparam int STACK_DEPTH = 4;
	localparam int PACE_W = 13;
	localparam int REG_OFS_W = 5;

	// register offsets, byte addresses
	localparam logic [REG_OFS_W-1:0] REG_STACK0 = 5'h00;
	localparam logic [REG_OFS_W-1:0] REG_STACK1 = 5'h04;
	localparam logic [REG_OFS_W-1:0] REG_STACK2 = 5'h08;
	localparam logic [REG_OFS_W-1:0] REG_STACK3 = 5'h0c;
	localparam logic [REG_OFS_W-1:0] REG_COMMAND = 5'h10;
	localparam logic [REG_OFS_W-1:0] REG_STATUS = 5'h14;

	// status field positions
	localparam int ST_BUSY = 7;
	localparam int ST_SIGN = 6;
	localparam int ST_ZERO = 5;
	localparam int ST_ERR_LSB = 1;
	localparam int ST_CARRY = 0;
	localparam int CMD_SVC_BIT = 7;

	// error field codes
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_DIV0 = 4'h8;
	localparam logic [3:0] ERR_RANGE = 4'hc;
	localparam logic [3:0] ERR_UNDER = 4'h2;
	localparam logic [3:0] ERR_OVER = 4'h6;

	// command codes without the service request bit
	localparam logic [6:0] OP_FIXED_DIVIDE_32 = 7'h2f;
	localparam logic [6:0] OP_FIXED_MUL_HIGH_32 = 7'h36;
	localparam logic [6:0] OP_FIXED_MUL_LOW_32 = 7'h2e;
	localparam logic [6:0] OP_FIXED_SUBTRACT_32 = 7'h2d;
	localparam logic [6:0] OP_NATURAL_POWER_FLOAT = 7'h0a;
	localparam logic [6:0] OP_FLOAT_DIVIDE = 7'h13;
	localparam logic [6:0] OP_FLOAT_ADD = 7'h10;
	localparam logic [6:0] OP_FLOAT_TO_FIXED32 = 7'h1e;
	localparam logic [6:0] OP_FLOAT_TO_FIXED16 = 7'h1f;
	localparam logic [6:0] OP_FIXED32_TO_FLOAT = 7'h1c;

	// execution times in core clock cycles
	localparam logic [PACE_W-1:0] CYC_DIV = 13'h0c4;
	localparam logic [PACE_W-1:0] CYC_DIV_ZERO = 13'h012;
	localparam logic [PACE_W-1:0] CYC_MUL_HIGH = 13'h0b6;
	localparam logic [PACE_W-1:0] CYC_MUL_LOW = 13'h0c2;
	localparam logic [PACE_W-1:0] CYC_SUB = 13'h026;
	localparam logic [PACE_W-1:0] CYC_EXP = 13'h0ed2;
	localparam logic [PACE_W-1:0] CYC_EXP_RANGE = 13'h022;
	localparam logic [PACE_W-1:0] CYC_FLOAT_DIVIDE = 13'h09a;
	localparam logic [PACE_W-1:0] CYC_FLOAT_DIVIDE_ZERO = 13'h016;
	localparam logic [PACE_W-1:0] CYC_FLOAT_ADD = 13'h036;
	localparam logic [PACE_W-1:0] CYC_FLOAT_ADD_ZERO = 13'h018;
	localparam logic [PACE_W-1:0] CYC_FIX = 13'h05a;
	localparam logic [PACE_W-1:0] CYC_FLT = 13'h038;
	localparam logic [PACE_W-1:0] CYC_OTHER = 13'h004;

	// number formats
	localparam logic [31:0] MOST_NEG = 32'h80000000;
	localparam logic [31:0] FLT_ONE = 32'h01800000;
	localparam logic [23:0] MANT_HALF = 24'h800000;
	localparam logic signed [6:0] EXP_LIMIT = 7'sh06;
	localparam logic [24:0] LOG2E_Q24 = 25'h1715476;
	localparam logic [23:0] EXP_C1 = 24'ha81067;
	localparam logic [23:0] EXP_C2 = 24'h57ef9e;

	typedef enum logic {SAC_IDLE, SAC_BUSY} sac_state_type;

	typedef struct packed {
		sac_state_type st;
		logic [7:0] cmd;
		logic [STACK_DEPTH-1:0][31:0] stk;
		logic sgn;
		logic zro;
		logic cry;
		logic [3:0] err;
		logic svc;
		logic ack;
		logic [31:0] rdat;
	} sac_regs_type;

	typedef struct packed {
		logic [PACE_W-1:0] cnt;
	} sac_pace_type;

endpackage

/* File: logic/sac_pacer.sv */
// command pacer: counts out the execution time of one command
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/10ps
module sac_pacer import sac_pkg::*; #(
	parameter int W = PACE_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic done
);

	sac_pace_type cur;
	sac_pace_type next_cur;

	generate
		if (W < 13 || W > PACE_W) begin : g_chk
			$error("sac_pacer: W must fit the longest command and the count");
		end
	endgenerate

	// done is high in the last cycle, so the owner commits on the edge
	// that completes exactly load cycles after start
	assign done = (cur.cnt == 13'h001);

	always_comb begin
		next_cur = cur;
		if (start) begin
			next_cur.cnt = load;
		end else if (cur.cnt != '0) begin
			next_cur.cnt = cur.cnt - 13'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

endmodule

/* File: logic/sac_unit.sv */
// stack arithmetic command unit with a classic Wishbone register slave
// assumes single-cycle Wishbone master, synchronous active-low reset
// Operation
// RL1: fixed divide replaces next-on-stack by integer quotient, stack moves up
// RL2: fixed divide takes 196 cycles, 18 when divisor is zero
// RL3: zero divisor returns dividend unchanged and flags divide by zero
// RL4: most negative fixed divide operand flags overflow
// RL5: upper multiply keeps high 32 product bits, stack moves up
// RL6: upper multiply flags overflow on a most negative operand
// RL7: lower multiply keeps low 32 product bits, stack moves up
// RL8: lower multiply overflows on lost upper half; most negative returned (low 32 bits kept unless an operand is most negative)
// RL9: fixed subtract next minus top in 38 cycles, stack moves up
// RL10: subtract borrow shows in the carry status bit
// RL11: subtract overflow on most negative subtrahend or range; low bits kept
// RL12: e to the x replaces top; 3794 cycles, 34 out of range
// RL13: exponent input beyond plus or minus 32 gives error code 1100
// RL14: float divide next by top, stack up; 154 cycles, 22 for zero
// RL15: float divide by zero returns dividend and flags divide by zero
// RL16: float exponent out of range flagged, exponent wrapped by 128
// RL17: float add puts normalized sum on top; 54 cycles, 24 zero top
// RL18: float to fixed32 overflows above 31 bits, keeps operand, loses fourth
// RL19: float to fixed16 writes lower half, stack moves up two bytes
// RL20: float to fixed16 overflows above 15 bits, keeps operand, loses fourth
// RL21: fixed32 to float replaces top in 56 cycles, loses fourth entry
// RL22: command bit 7 chooses whether completion raises service request
// RL23: every command updates sign and zero plus its own flags
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
module sac_unit import sac_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [ADDR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// completion
	output logic SVC_REQ
);

	sac_regs_type cur;
	sac_regs_type next_cur;
	logic launch;
	logic done;
	logic [PACE_W-1:0] lat;
	logic [3:0][31:0] r_stk;
	logic r_sgn;
	logic r_zro;
	logic r_cry;
	logic [3:0] r_err;

	generate
		if (ADDR_W < REG_OFS_W) begin : g_chk
			$error("sac_unit: ADDR_W too small for the register map");
		end
	endgenerate

	function automatic logic [5:0] lzc49(input logic [48:0] v);
		logic [5:0] n;
		logic hit;
		n = 6'd49;
		hit = 1'b0;
		for (int i = 48; i >= 0; i--) begin
			if (v[i] && !hit) begin
				n = 6'(48 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction

	function automatic logic [9:0] fexp(input logic [31:0] x);
		return {{3{x[30]}}, x[30:24]};
	endfunction

	// out-of-range exponent keeps its low 7 bits, i.e. wraps by 128
	function automatic logic [3:0] frange(input logic signed [9:0] e);
		if (e > 10'sd63) begin
			return ERR_OVER;
		end else if (e < -10'sd64) begin
			return ERR_UNDER;
		end
		return ERR_NONE;
	endfunction

	function automatic logic exp_big(input logic [31:0] x);
		return x[23] && ($signed(x[30:24]) > EXP_LIMIT ||
			($signed(x[30:24]) == EXP_LIMIT && x[23:0] != MANT_HALF));
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [PACE_W-1:0] lat_of(input logic [6:0] op,
		input logic [31:0] top);
		case (op)
			OP_FIXED_DIVIDE_32: return (top == '0) ? CYC_DIV_ZERO : CYC_DIV; // RL2
			OP_FIXED_MUL_HIGH_32: return CYC_MUL_HIGH; // RL5
			OP_FIXED_MUL_LOW_32: return CYC_MUL_LOW; // RL7
			OP_FIXED_SUBTRACT_32: return CYC_SUB; // RL9
			OP_NATURAL_POWER_FLOAT: return exp_big(top) ? CYC_EXP_RANGE : CYC_EXP; // RL12
			OP_FLOAT_DIVIDE: return top[23] ? CYC_FLOAT_DIVIDE : CYC_FLOAT_DIVIDE_ZERO; // RL14
			OP_FLOAT_ADD: return top[23] ? CYC_FLOAT_ADD : CYC_FLOAT_ADD_ZERO; // RL17
			OP_FLOAT_TO_FIXED32: return CYC_FIX; // RL18
			OP_FLOAT_TO_FIXED16: return CYC_FIX; // RL19
			OP_FIXED32_TO_FLOAT: return CYC_FLT; // RL21
			default: return CYC_OTHER;
		endcase
	endfunction

	sac_pacer #(.W(PACE_W)) u_pacer (
		.clk(CORE_CLK),
		.nrst(NRST),
		.start(launch),
		.load(lat),
		.done(done)
	);

	// result of the pending command; operands cannot change while busy
	always_comb begin
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		logic signed [63:0] prod;
		logic [32:0] dif;
		logic [9:0] ea;
		logic [9:0] eb;
		logic [9:0] eo;
		logic [9:0] dsh;
		logic [48:0] big;
		logic [48:0] sml;
		logic [48:0] sum;
		logic [48:0] q;
		logic [5:0] lz;
		logic so;
		logic [55:0] wide;
		logic [31:0] mag;
		logic [54:0] ep;
		logic [31:0] ys;
		logic [47:0] pq;
		logic [23:0] u;
		logic f16;
		a = cur.stk[0];
		b = cur.stk[1];
		r = '0;
		prod = '0;
		dif = '0;
		ea = fexp(a);
		eb = fexp(b);
		eo = '0;
		dsh = '0;
		big = '0;
		sml = '0;
		sum = '0;
		q = '0;
		lz = '0;
		so = 1'b0;
		wide = '0;
		mag = '0;
		ep = '0;
		ys = '0;
		pq = '0;
		u = '0;
		f16 = 1'b0;
		r_cry = 1'b0;
		r_err = ERR_NONE;
		// binary commands move the stack up; old top rotates to bottom
		r_stk[1] = cur.stk[2];
		r_stk[2] = cur.stk[3];
		r_stk[3] = a;
		case (cur.cmd[6:0])
			OP_FIXED_DIVIDE_32: begin
				if (a == '0) begin
					r = b; // RL3
					r_err = ERR_DIV0; // RL3
				end else if (a == MOST_NEG || b == MOST_NEG) begin
					r_err = ERR_OVER; // RL4
				end else begin
					r = 32'($signed(b) / $signed(a)); // RL1
				end
			end
			OP_FIXED_MUL_HIGH_32, OP_FIXED_MUL_LOW_32: begin
				prod = $signed(a) * $signed(b);
				if (cur.cmd[6:0] == OP_FIXED_MUL_HIGH_32) begin
					r = prod[63:32]; // RL5
					if (a == MOST_NEG || b == MOST_NEG) begin
						r_err = ERR_OVER; // RL6
					end
				end else if (a == MOST_NEG || b == MOST_NEG) begin
					r = MOST_NEG; // RL8
					r_err = ERR_OVER; // RL8
				end else begin
					r = prod[31:0]; // RL7
					// upper half counts as lost unless it is sign fill
					if (prod[63:32] != {32{prod[31]}}) begin
						r_err = ERR_OVER; // RL8
					end
				end
			end
			OP_FIXED_SUBTRACT_32: begin
				dif = {1'b0, b} - {1'b0, a};
				r = dif[31:0]; // RL9 RL11
				r_cry = dif[32]; // RL10
				if (a == MOST_NEG || (a[31] != b[31] && r[31] != b[31])) begin
					r_err = ERR_OVER; // RL11
				end
			end
			OP_FLOAT_DIVIDE: begin
				so = a[31] ^ b[31];
				if (!a[23]) begin
					r = b; // RL15
					r_err = ERR_DIV0; // RL15
				end else if (b[23]) begin
					q = {b[23:0], 25'h0} / {25'h0, a[23:0]}; // RL14
					eo = eb - ea + {9'h0, q[25]};
					r = {so, eo[6:0], q[25] ? q[25:2] : q[24:1]}; // RL16
					r_err = frange(eo); // RL16
				end
			end
			OP_FLOAT_ADD: begin
				if (!a[23]) begin
					r = b; // RL17
				end else if (!b[23]) begin
					r = a; // RL17
				end else begin
					if ($signed(ea) >= $signed(eb)) begin
						big = {1'b0, a[23:0], 24'h0};
						sml = {1'b0, b[23:0], 24'h0};
						dsh = ea - eb;
						eo = ea;
						so = a[31];
					end else begin
						big = {1'b0, b[23:0], 24'h0};
						sml = {1'b0, a[23:0], 24'h0};
						dsh = eb - ea;
						eo = eb;
						so = b[31];
					end
					sml = (dsh > 10'd48) ? '0 : sml >> dsh;
					if (a[31] == b[31]) begin
						sum = big + sml;
					end else if (big >= sml) begin
						sum = big - sml;
					end else begin
						sum = sml - big;
						so = ~so;
					end
					lz = lzc49(sum);
					sum = sum << lz;
					eo = eo + 10'h001 - {4'h0, lz};
					if (sum[48]) begin
						r = {so, eo[6:0], sum[48:25]}; // RL17 RL16
						r_err = frange(eo); // RL16
					end
				end
			end
			default: begin
				// unary commands keep the second and third entries, except float to fixed16 when in range
				r_stk[1] = b;
				r_stk[2] = cur.stk[2];
				r_stk[3] = '0; // RL18 RL20 RL21
				r = a;
				case (cur.cmd[6:0])
					OP_NATURAL_POWER_FLOAT: begin
						if (!a[23]) begin
							r = FLT_ONE; // RL12
						end else if (exp_big(a)) begin
							r_err = ERR_RANGE; // RL13
						end else begin
							wide = $signed(ea) >= 0 ?
								{32'h0, a[23:0]} << ea[2:0] :
								{32'h0, a[23:0]} >> (10'h000 - ea);
							ep = wide[29:0] * LOG2E_Q24;
							ys = a[31] ? 32'h0 - {1'b0, ep[54:24]} :
								{1'b0, ep[54:24]};
							// 2^f by a two-term fit, relative error near 1e-3
							pq = ys[23:0] * EXP_C2;
							pq = ys[23:0] * (EXP_C1 + pq[47:24]);
							u = pq[47:24];
							eo = {{2{ys[31]}}, ys[31:24]} + 10'h001;
							r = {1'b0, eo[6:0], 1'b1, u[23:1]}; // RL12
							r_err = frange(eo); // RL16
						end
					end
					OP_FLOAT_TO_FIXED32, OP_FLOAT_TO_FIXED16: begin
						f16 = cur.cmd[6:0] == OP_FLOAT_TO_FIXED16;
						if (!a[23] || $signed(ea) <= 0) begin
							r = '0;
						end else if ($signed(ea) > (f16 ? 10'sd15 : 10'sd31)) begin
							r_err = ERR_OVER; // RL18 RL20
							f16 = 1'b0;
						end else begin
							wide = {32'h0, a[23:0]} << ea[4:0];
							mag = wide[55:24];
							r = a[31] ? 32'h0 - mag : mag; // RL18
						end
						if (f16) begin
							// 16-bit view: high half of an entry is on top
							r = {r[15:0], b[31:16]}; // RL19
							r_stk[1] = {b[15:0], cur.stk[2][31:16]};
							r_stk[2] = {cur.stk[2][15:0], cur.stk[3][31:16]};
							r_stk[3] = {cur.stk[3][15:0], 16'h0}; // RL20
						end
					end
					OP_FIXED32_TO_FLOAT: begin
						mag = a[31] ? 32'h0 - a : a;
						lz = lzc49({mag, 17'h0});
						mag = mag << lz[4:0];
						eo = 10'd32 - {4'h0, lz};
						r = (a == '0) ? '0 : {a[31], eo[6:0], mag[31:8]}; // RL21
					end
					default: begin
						r = a;
						r_stk[3] = cur.stk[3];
					end
				endcase
			end
		endcase
		r_stk[0] = r;
		// fixed results judge zero on all bits, fixed16 on the top half, floats on mantissa msb
		case (cur.cmd[6:0])
			OP_FLOAT_DIVIDE, OP_FLOAT_ADD, OP_NATURAL_POWER_FLOAT,
			OP_FIXED32_TO_FLOAT: begin
				r_sgn = r[31]; // RL23
				r_zro = !r[23]; // RL23
			end
			OP_FLOAT_TO_FIXED16: begin
				r_sgn = r[31]; // RL23
				r_zro = r[31:16] == '0; // RL23
			end
			default: begin
				r_sgn = r[31]; // RL23
				r_zro = r == '0; // RL23
			end
		endcase
	end

	always_comb begin
		logic req;
		logic hit_hi;
		logic [REG_OFS_W-1:0] ofs;
		req = WB_CYC_I && WB_STB_I && !cur.ack;
		hit_hi = (WB_ADR_I >> REG_OFS_W) == '0;
		ofs = WB_ADR_I[REG_OFS_W-1:0];
		next_cur = cur;
		next_cur.ack = 1'b0;
		launch = 1'b0;
		lat = lat_of(WB_DAT_I[6:0], cur.stk[0]);
		if (req) begin
			next_cur.ack = 1'b1;
			next_cur.rdat = '0;
			if (!hit_hi) begin
				next_cur.rdat = '0;
			end else if (ofs == REG_STACK0 || ofs == REG_STACK1 ||
				ofs == REG_STACK2 || ofs == REG_STACK3) begin
				next_cur.rdat = cur.stk[ofs[3:2]];
				// operands are frozen while a command runs
				if (WB_WE_I && cur.st == SAC_IDLE) begin
					next_cur.stk[ofs[3:2]] = merge(cur.stk[ofs[3:2]],
						WB_DAT_I, WB_SEL_I);
				end
			end else if (ofs == REG_COMMAND) begin
				next_cur.rdat = {24'h0, cur.cmd};
				if (WB_WE_I && WB_SEL_I[0] && cur.st == SAC_IDLE) begin
					launch = 1'b1;
					next_cur.st = SAC_BUSY;
					next_cur.cmd = WB_DAT_I[7:0];
					next_cur.svc = 1'b0; // RL22
				end
			end else if (ofs == REG_STATUS) begin
				next_cur.rdat = {24'h0, cur.st == SAC_BUSY, cur.sgn,
					cur.zro, cur.err, cur.cry};
			end
		end
		if (cur.st == SAC_BUSY && done) begin
			next_cur.st = SAC_IDLE;
			next_cur.stk = r_stk;
			next_cur.sgn = r_sgn;
			next_cur.zro = r_zro;
			next_cur.cry = r_cry;
			next_cur.err = r_err;
			next_cur.svc = cur.cmd[CMD_SVC_BIT]; // RL22
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign WB_DAT_O = cur.rdat;
	assign WB_ACK_O = cur.ack;
	assign SVC_REQ = cur.svc;

	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	sequence sq_launch(logic [6:0] op);
		launch && WB_DAT_I[6:0] == op;
	endsequence

	sequence sq_commit(logic [6:0] op);
		done && cur.st == SAC_BUSY && cur.cmd[6:0] == op;
	endsequence

	div_zero_time_a: assert property ( // RL2
		sq_launch(OP_FIXED_DIVIDE_32) ##0 cur.stk[0] == '0 |-> ##18 done)
		else $error("divide by zero not done in 18 cycles");
	sub_time_a: assert property ( // RL9
		sq_launch(OP_FIXED_SUBTRACT_32) |=> !done [*8] ##30 done)
		else $error("subtract not done in 38 cycles");
	div_zero_res_a: assert property ( // RL3
		sq_commit(OP_FIXED_DIVIDE_32) ##0 cur.stk[0] == '0 |=>
		cur.stk[0] == $past(cur.stk[1]) && cur.err == ERR_DIV0)
		else $error("divide by zero result wrong");
	mul_low_res_a: assert property ( // RL7
		sq_commit(OP_FIXED_MUL_LOW_32) ##0 cur.stk[0] != MOST_NEG
		##0 cur.stk[1] != MOST_NEG |=>
		cur.stk[0] == 32'($past(cur.stk[0]) * $past(cur.stk[1])))
		else $error("lower multiply result wrong");
	sub_borrow_a: assert property ( // RL10
		sq_commit(OP_FIXED_SUBTRACT_32) |=>
		cur.cry == ($past(cur.stk[1]) < $past(cur.stk[0])))
		else $error("subtract borrow wrong");
	sub_stack_a: assert property ( // RL9
		sq_commit(OP_FIXED_SUBTRACT_32) |=> cur.stk[3] ==
		$past(cur.stk[0]) && cur.stk[1] == $past(cur.stk[2]))
		else $error("subtract stack move wrong");
	svc_req_a: assert property ( // RL22
		done && cur.st == SAC_BUSY |=>
		SVC_REQ == $past(cur.cmd[CMD_SVC_BIT]) && cur.st == SAC_IDLE)
		else $error("service request does not follow command");
	busy_hold_a: assert property ( // RL23
		cur.st == SAC_BUSY && !done |=> $stable(cur.stk) && $stable(cur.err))
		else $error("stack changed while busy");
	ack_pulse_a: assert property (
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("bus ack not a single cycle pulse");

endmodule

/* File: verif/sac_host_model.sv */
// host side of the unit: a classic wishbone master that loads the stack,
// reads registers back and issues command bytes; shares the core clock
`timescale 1ns/10ps
module sac_host_model import sac_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// clock
	input wire logic clk,
	// wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [ADDR_W-1:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack
);
	int hangs = 0;

	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = '0;
		sel = 4'h0;
		dat_o = 32'h0;
	end

	// a missing ack is counted, not waited on forever
	task automatic xfer(input logic w, input logic [4:0] ofs,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ADDR_W'(ofs);
		sel <= s;
		dat_o <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		q = dat_i;
		if (ack !== 1'b1)
			hangs++;
		cyc <= 1'b0;
		stb <= 1'b0;
		// released lines must not keep looking valid
		adr <= ~adr;
		dat_o <= ~dat_o;
	endtask

	task automatic wr(input logic [4:0] o, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, o, d, 4'hf, q);
	endtask

	task automatic rd(input logic [4:0] o, output logic [31:0] q);
		xfer(1'b0, o, 32'h0, 4'hf, q);
	endtask

	task automatic cmd(input logic [6:0] op, input logic svc);
		logic [31:0] q;
		xfer(1'b1, REG_COMMAND, {24'h0, svc, op}, 4'h1, q);
	endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the stack arithmetic command unit
// assumes the host model drives the register bus on the core clock
`timescale 1ns/10ps
module tb import sac_pkg::*; ();
	localparam logic [31:0] CV = 32'h1234abcd;
	localparam logic [31:0] DV = 32'h5678ef01;
	logic clk;
	logic nrst;
	logic cyc, stb, we, ack, svc;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, st;
	logic [31:0] rs [4];
	int fail_count = 0;
	int n_tests = 0;

	sac_unit dut (.CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SVC_REQ(svc));
	sac_host_model host (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .dat_o(wdat), .dat_i(rdat), .ack(ack));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic tally_and_finish();
		fail_count += host.hangs;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: field %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_cyc(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			fail_count++;
			$display("ERROR %0t: %0d cycles, not %0d", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] stv(input logic [2:0] szc,
		input logic [3:0] e);
		return {24'h0, 1'b0, szc[2:1], e, szc[0]};
	endfunction

	// with service request the run is timed exactly; without it the busy
	// bit is read in the last busy cycle and again three cycles after the expected end
	task automatic exec(input logic [6:0] op, input logic s,
		input logic [31:0] a, input logic [31:0] b, input int lat);
		int k;
		host.wr(REG_STACK0, a);
		host.wr(REG_STACK1, b);
		host.wr(REG_STACK2, CV);
		host.wr(REG_STACK3, DV);
		host.cmd(op, s);
		if (s) begin
			for (k = 1; k < 6000; k++) begin
				@(negedge clk);
				if (svc === 1'b1)
					break;
				@(posedge clk);
			end
			cmp_cyc(k, lat);
		end else begin
			repeat (lat - 3) @(posedge clk);
			host.rd(REG_STATUS, st);
			cmp4({3'h0, st[ST_BUSY]}, 4'h1);
			host.rd(REG_STATUS, st);
			cmp4({3'h0, st[ST_BUSY]}, 4'h0);
			cmp4({3'h0, svc}, 4'h0);
		end
		for (k = 0; k < 4; k++)
			host.rd(5'(4 * k), rs[k]);
		host.rd(REG_STATUS, st);
	endtask

	task automatic bin_chk(input logic [31:0] a);
		cmp32(rs[1], CV);
		cmp32(rs[2], DV);
		cmp32(rs[3], a);
	endtask

	task automatic una_chk(input logic [31:0] b);
		cmp32(rs[1], b);
		cmp32(rs[2], CV);
		cmp32(rs[3], 32'h0);
	endtask

	task automatic t_reset();
		host.rd(REG_STACK0, rs[0]);
		cmp32(rs[0], 32'h0);
		host.wr(REG_STATUS, 32'hff);
		host.rd(REG_STATUS, st);
		cmp32(st, 32'h0);
		host.rd(5'h18, rs[1]);
		cmp32(rs[1], 32'h0);
		cmp4({3'h0, svc}, 4'h0);
	endtask

	task automatic t_div();
		exec(OP_FIXED_DIVIDE_32, 1'b1, 32'h7, 32'h64, 196);
		cmp32(rs[0], 32'he);
		bin_chk(32'h7);
		cmp32(st, stv(3'b000, ERR_NONE));
		exec(OP_FIXED_DIVIDE_32, 1'b1, 32'h0, 32'h64, 18);
		cmp32(rs[0], 32'h64);
		cmp4(st[4:1], ERR_DIV0);
		exec(OP_FIXED_DIVIDE_32, 1'b1, 32'h7, MOST_NEG, 196);
		cmp4(st[4:1], ERR_OVER);
	endtask

	task automatic t_mul();
		exec(OP_FIXED_MUL_HIGH_32, 1'b1, 32'h10000, 32'h30000, 182);
		cmp32(rs[0], 32'h3);
		bin_chk(32'h10000);
		exec(OP_FIXED_MUL_HIGH_32, 1'b1, MOST_NEG, 32'h2, 182);
		cmp4(st[4:1], ERR_OVER);
		exec(OP_FIXED_MUL_LOW_32, 1'b1, 32'h12345, 32'h10, 194);
		cmp32(rs[0], 32'h123450);
		bin_chk(32'h12345);
		exec(OP_FIXED_MUL_LOW_32, 1'b1, 32'h10000, 32'h30000, 194);
		cmp32(st, stv(3'b010, ERR_OVER));
		exec(OP_FIXED_MUL_LOW_32, 1'b1, MOST_NEG, 32'h3, 194);
		cmp32(rs[0], MOST_NEG);
		cmp4(st[4:1], ERR_OVER);
	endtask

	task automatic t_sub();
		exec(OP_FIXED_SUBTRACT_32, 1'b0, 32'h7, 32'h5, 38);
		cmp32(rs[0], 32'hfffffffe);
		bin_chk(32'h7);
		cmp32(st, stv(3'b101, ERR_NONE));
		exec(OP_FIXED_SUBTRACT_32, 1'b0, 32'hffffffff, 32'h7fffffff, 38);
		cmp32(rs[0], MOST_NEG);
		cmp4(st[4:1], ERR_OVER);
		exec(OP_FIXED_SUBTRACT_32, 1'b0, MOST_NEG, 32'h0, 38);
		cmp4(st[4:1], ERR_OVER);
	endtask

	task automatic t_float();
		exec(OP_NATURAL_POWER_FLOAT, 1'b1, 32'h06800000, CV, 3794);
		cmp32(st, stv(3'b000, ERR_NONE));
		cmp32({rs[0][31:23], 23'h0}, 32'h2f800000);
		cmp32(rs[1], CV);
		exec(OP_NATURAL_POWER_FLOAT, 1'b1, 32'h0, CV, 3794);
		cmp32(rs[0], FLT_ONE);
		exec(OP_NATURAL_POWER_FLOAT, 1'b1, 32'h06840000, CV, 34);
		cmp4(st[4:1], ERR_RANGE);
		exec(OP_FLOAT_DIVIDE, 1'b1, 32'h00800000, FLT_ONE, 154);
		cmp32(rs[0], 32'h02800000);
		bin_chk(32'h00800000);
		exec(OP_FLOAT_DIVIDE, 1'b1, 32'h0, FLT_ONE, 22);
		cmp32(rs[0], FLT_ONE);
		cmp4(st[4:1], ERR_DIV0);
		exec(OP_FLOAT_ADD, 1'b1, FLT_ONE, FLT_ONE, 54);
		cmp32(rs[0], 32'h02800000);
		exec(OP_FLOAT_ADD, 1'b1, 32'h0, FLT_ONE, 24);
		cmp32(rs[0], FLT_ONE);
		exec(OP_FLOAT_ADD, 1'b1, 32'h3f800000, 32'h3f800000, 54);
		cmp32(rs[0], 32'h40800000);
		cmp4(st[4:1], ERR_OVER);
	endtask

	task automatic t_conv();
		exec(OP_FLOAT_TO_FIXED32, 1'b1, FLT_ONE, 32'h77, 90);
		cmp32(rs[0], 32'h1);
		una_chk(32'h77);
		exec(OP_FLOAT_TO_FIXED32, 1'b1, 32'h20800000, 32'h77, 90);
		cmp32(rs[0], 32'h20800000);
		cmp32(rs[3], 32'h0);
		cmp4(st[4:1], ERR_OVER);
		exec(OP_FLOAT_TO_FIXED16, 1'b1, 32'h09960000, 32'habcd1234, 90);
		cmp32(rs[0], 32'h012cabcd);
		cmp32(rs[1], {16'h1234, CV[31:16]});
		exec(OP_FLOAT_TO_FIXED16, 1'b1, 32'h10800000, 32'h77, 90);
		cmp32(rs[0], 32'h10800000);
		cmp4(st[4:1], ERR_OVER);
		exec(OP_FIXED32_TO_FLOAT, 1'b1, 32'h3, 32'h77, 56);
		cmp32(rs[0], 32'h02c00000);
		una_chk(32'h77);
		exec(7'h00, 1'b1, 32'h7, 32'h77, 4);
		cmp32(rs[0], 32'h7);
		cmp32(rs[3], DV);
		cmp32(st, 32'h0);
	endtask

	initial begin
		nrst = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_div();
		t_mul();
		t_sub();
		t_float();
		t_conv();
		tally_and_finish();
	end

	// whole run is near 11000 cycles; nearly twice that means a hang
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("ERROR %0t: run did not finish", $time);
		tally_and_finish();
	end
endmodule
